/* verilog/hotswap_warn_limits_and_status_flags.sv */
// Warning thresholds, sticky status flags and alert output of the monitor.
//
// Functional notes
// - Averaged temperature above warn threshold sets temperature flags and alert.
// - Temperature threshold 0..0FFEh, resets 07D0h, top code disables detection.
// - Temperature compared only as average of 16 round-robin samples.
// - Input voltage above over-voltage threshold sets its warn flags and alert.
// - Over-voltage threshold 0..0FFEh, 0FFFh disables and is the reset value.
// - Input voltage below under-voltage threshold sets its warn flags and alert.
// - Under-voltage threshold 1..0FFFh, 0000h disables and is the reset value.
// - Thresholds are read and written as full 16-bit words.
// - Flags are sticky; host removes cause then issues fault clear.
// - Summary bit 6 reads 1 whenever the switch is off; resets to 1.
// - Summary bits 3,2,1,0: input UV fault, temperature, comms, other.
// - Unsupported status bits always read zero.
// - Word bits 15,13,12,11: output, input, vendor, power-good negated.
// - Word low byte equals summary byte; bit 0 covers everything else.
// - Input and UV fault summary flags start at 1, clear at first lockout exit.
// - Input UV warn bit starts at 1, clears at first lockout exit.
// - Output voltage flags: only bit 5, output UV warning, is live.
// - Input flags 7..4 OV fault, OV warn, UV warn, UV fault; 2..0 OC/OP.
// - Status reads change no flag.
// - Fault clear command resets flags and alert; present conditions set again.
`timescale 1ns/1ps
`default_nettype none
module hotswap_warn_limits_and_status_flags (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Register access from the protocol engine.
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_write,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_read,
	output logic      [15:0] reg_rdata,
	input  wire logic        send_byte,
	input  wire logic [7:0]  send_cmd,
	// Telemetry.
	input  wire logic [11:0] temp_sample,
	input  wire logic        temp_sample_valid,
	input  wire logic [11:0] input_voltage,
	input  wire logic        input_voltage_valid,
	// Condition events from the rest of the device.
	input  wire logic        switch_on,
	input  wire logic        above_lockout,
	input  wire logic        input_undervolt_fault_event,
	input  wire logic        input_overvolt_fault_event,
	input  wire logic        input_overcurrent_fault_event,
	input  wire logic        input_overcurrent_warn_event,
	input  wire logic        input_overpower_warn_event,
	input  wire logic        output_undervolt_warn_event,
	input  wire logic        over_temp_fault_event,
	input  wire logic        communication_fault_event,
	input  wire logic        vendor_specific_event,
	input  wire logic        power_good_negated_event,
	// Alert line, open drain: enable low means pulled low.
	output logic             alert_out,
	output logic             alert_oe_n
);
	logic [15:0] ot_thr_reg, ot_thr_next;
	logic [15:0] ov_thr_reg, ov_thr_next;
	logic [15:0] uv_thr_reg, uv_thr_next;
	logic        ot_warn_reg, ot_warn_next;
	logic        ot_fault_reg, ot_fault_next;
	logic        ov_warn_reg, ov_warn_next;
	logic        uv_warn_reg, uv_warn_next;
	logic        uv_fault_reg, uv_fault_next;
	logic        ov_fault_reg, ov_fault_next;
	logic        oc_fault_reg, oc_fault_next;
	logic        oc_warn_reg, oc_warn_next;
	logic        op_warn_reg, op_warn_next;
	logic        output_voltage_uv_reg, output_voltage_uv_next;
	logic        comm_reg, comm_next;
	logic        vendor_reg, vendor_next;
	logic        pgood_reg, pgood_next;
	logic        startup_reg, startup_next;
	logic [15:0] rdata_reg, rdata_next;
	logic        lockout_meta_reg, lockout_sync_reg;
	logic [11:0] temp_avg;
	logic        temp_avg_valid;
	logic        clear_all;
	logic        ot_hit, ov_hit, uv_hit;
	logic [7:0]  summary_low;
	logic [15:0] summary_full;
	logic [7:0]  output_voltage_flags;
	logic [7:0]  input_flags;

	// Averaging lives in its own module so detection sees only full averages.
	temp_averager averager (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.sample        (temp_sample),
		.sample_valid  (temp_sample_valid),
		.average       (temp_avg),
		.average_valid (temp_avg_valid)
	);

	// A threshold at its disabling code never matches.
	function automatic logic above_limit(input logic [11:0] value,
		input logic [15:0] limit);
		above_limit = (limit[11:0] != hotswap_flags_pkg::threshold_disable_high)
			&& (value > limit[11:0]);
	endfunction

	assign clear_all = send_byte
		&& (send_cmd == hotswap_flags_pkg::clear_faults_cmd);
	assign ot_hit = temp_avg_valid && above_limit(temp_avg, ot_thr_reg);
	assign ov_hit = input_voltage_valid
		&& above_limit(input_voltage, ov_thr_reg);
	assign uv_hit = input_voltage_valid
		&& (uv_thr_reg[11:0] != hotswap_flags_pkg::threshold_disable_low)
		&& (input_voltage < uv_thr_reg[11:0]);

	// Threshold writes store the whole word.
	always_comb begin
		ot_thr_next = ot_thr_reg;
		ov_thr_next = ov_thr_reg;
		uv_thr_next = uv_thr_reg;
		if (reg_write) begin
			case (reg_addr)
			hotswap_flags_pkg::over_temp_warn_threshold_addr: begin
				ot_thr_next = reg_wdata;
			end
			hotswap_flags_pkg::input_overvolt_warn_threshold_addr: begin
				ov_thr_next = reg_wdata;
			end
			hotswap_flags_pkg::input_undervolt_warn_threshold_addr: begin
				uv_thr_next = reg_wdata;
			end
			default: begin
			end
			endcase
		end
	end

	// Sticky flags: a new event in the clearing cycle wins over the clear.
	always_comb begin
		ot_warn_next  = (ot_warn_reg && !clear_all) || ot_hit;
		ot_fault_next = (ot_fault_reg && !clear_all) || over_temp_fault_event;
		ov_warn_next  = (ov_warn_reg && !clear_all) || ov_hit;
		uv_warn_next  = (uv_warn_reg && !clear_all) || uv_hit;
		uv_fault_next = (uv_fault_reg && !clear_all)
			|| input_undervolt_fault_event;
		ov_fault_next = (ov_fault_reg && !clear_all)
			|| input_overvolt_fault_event;
		oc_fault_next = (oc_fault_reg && !clear_all)
			|| input_overcurrent_fault_event;
		oc_warn_next  = (oc_warn_reg && !clear_all)
			|| input_overcurrent_warn_event;
		op_warn_next  = (op_warn_reg && !clear_all)
			|| input_overpower_warn_event;
		output_voltage_uv_next  = (output_voltage_uv_reg && !clear_all)
			|| output_undervolt_warn_event;
		comm_next     = (comm_reg && !clear_all) || communication_fault_event;
		vendor_next   = (vendor_reg && !clear_all) || vendor_specific_event;
		pgood_next    = (pgood_reg && !clear_all) || power_good_negated_event;
		// Startup flags drop on the first lockout exit and never return.
		startup_next  = startup_reg && !lockout_sync_reg;
	end

	// Status images; unsupported bits stay zero.
	always_comb begin
		summary_low = 8'h00;
		summary_low[hotswap_flags_pkg::summary_off_bit]   = !switch_on;
		summary_low[hotswap_flags_pkg::summary_in_uv_bit] = uv_fault_reg
			|| startup_reg;
		summary_low[hotswap_flags_pkg::summary_temp_bit]  = ot_warn_reg
			|| ot_fault_reg;
		summary_low[hotswap_flags_pkg::summary_comm_bit]  = comm_reg;
		// Bit 0 gathers every stored flag that bits 7 to 1 do not show.
		summary_low[hotswap_flags_pkg::summary_other_bit] = vendor_reg
			|| pgood_reg || output_voltage_uv_reg || ov_fault_reg || ov_warn_reg
			|| uv_warn_reg || oc_fault_reg || oc_warn_reg
			|| op_warn_reg;
		output_voltage_flags = 8'h00;
		output_voltage_flags[hotswap_flags_pkg::output_voltage_uv_warn_bit] = output_voltage_uv_reg;
		input_flags = 8'h00;
		input_flags[hotswap_flags_pkg::in_ov_fault_bit] = ov_fault_reg;
		input_flags[hotswap_flags_pkg::in_ov_warn_bit]  = ov_warn_reg;
		input_flags[hotswap_flags_pkg::input_undervolt_warn_flag_bit]  = uv_warn_reg
			|| startup_reg;
		input_flags[hotswap_flags_pkg::in_uv_fault_bit] = uv_fault_reg;
		input_flags[hotswap_flags_pkg::in_oc_fault_bit] = oc_fault_reg;
		input_flags[hotswap_flags_pkg::in_oc_warn_bit]  = oc_warn_reg;
		input_flags[hotswap_flags_pkg::in_op_warn_bit]  = op_warn_reg;
		summary_full = {8'h00, summary_low};
		summary_full[hotswap_flags_pkg::summary_output_voltage_bit]   = output_voltage_uv_reg;
		summary_full[hotswap_flags_pkg::summary_input_bit]  = (|input_flags);
		summary_full[hotswap_flags_pkg::summary_vendor_bit] = vendor_reg;
		summary_full[hotswap_flags_pkg::summary_pgood_bit]  = pgood_reg;
	end

	// Reads only sample the images; no flag changes on a read.
	always_comb begin
		rdata_next = rdata_reg;
		if (reg_read) begin
			case (reg_addr)
			hotswap_flags_pkg::over_temp_warn_threshold_addr: begin
				rdata_next = ot_thr_reg;
			end
			hotswap_flags_pkg::input_overvolt_warn_threshold_addr: begin
				rdata_next = ov_thr_reg;
			end
			hotswap_flags_pkg::input_undervolt_warn_threshold_addr: begin
				rdata_next = uv_thr_reg;
			end
			hotswap_flags_pkg::summary_flags_low_addr: begin
				rdata_next = {8'h00, summary_low};
			end
			hotswap_flags_pkg::summary_flags_full_addr: begin
				rdata_next = summary_full;
			end
			hotswap_flags_pkg::output_voltage_flags_addr: begin
				rdata_next = {8'h00, output_voltage_flags};
			end
			hotswap_flags_pkg::input_side_flags_addr: begin
				rdata_next = {8'h00, input_flags};
			end
			default: begin
				rdata_next = 16'h0000;
			end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ot_thr_reg       <= hotswap_flags_pkg::over_temp_warn_reset;
			ov_thr_reg       <= hotswap_flags_pkg::input_overvolt_warn_reset;
			uv_thr_reg       <= hotswap_flags_pkg::input_undervolt_warn_reset;
			ot_warn_reg      <= 1'b0;
			ot_fault_reg     <= 1'b0;
			ov_warn_reg      <= 1'b0;
			uv_warn_reg      <= 1'b0;
			uv_fault_reg     <= 1'b0;
			ov_fault_reg     <= 1'b0;
			oc_fault_reg     <= 1'b0;
			oc_warn_reg      <= 1'b0;
			op_warn_reg      <= 1'b0;
			output_voltage_uv_reg      <= 1'b0;
			comm_reg         <= 1'b0;
			// A fresh part has defaults loaded and power-good not yet up.
			vendor_reg       <= 1'b1;
			pgood_reg        <= 1'b1;
			startup_reg      <= 1'b1;
			rdata_reg        <= 16'h0000;
			lockout_meta_reg <= 1'b0;
			lockout_sync_reg <= 1'b0;
		end else begin
			ot_thr_reg       <= ot_thr_next;
			ov_thr_reg       <= ov_thr_next;
			uv_thr_reg       <= uv_thr_next;
			ot_warn_reg      <= ot_warn_next;
			ot_fault_reg     <= ot_fault_next;
			ov_warn_reg      <= ov_warn_next;
			uv_warn_reg      <= uv_warn_next;
			uv_fault_reg     <= uv_fault_next;
			ov_fault_reg     <= ov_fault_next;
			oc_fault_reg     <= oc_fault_next;
			oc_warn_reg      <= oc_warn_next;
			op_warn_reg      <= op_warn_next;
			output_voltage_uv_reg      <= output_voltage_uv_next;
			comm_reg         <= comm_next;
			vendor_reg       <= vendor_next;
			pgood_reg        <= pgood_next;
			startup_reg      <= startup_next;
			rdata_reg        <= rdata_next;
			lockout_meta_reg <= above_lockout;
			lockout_sync_reg <= lockout_meta_reg;
		end
	end

	assign reg_rdata = rdata_reg;
	// Alert pulls low while any stored warning or fault other than the startup flag is pending.
	assign alert_out  = 1'b0;
	assign alert_oe_n = !(ot_warn_reg || ot_fault_reg || ov_warn_reg
		|| uv_warn_reg || uv_fault_reg || ov_fault_reg || oc_fault_reg
		|| oc_warn_reg || op_warn_reg || output_voltage_uv_reg || comm_reg
		|| vendor_reg || pgood_reg);
endmodule // hotswap_warn_limits_and_status_flags
`default_nettype wire

/* pkg/hotswap_flags_pkg.sv */
// Package with register map, reset values, bit positions and timing for the warning block.
package hotswap_flags_pkg;
	// Register offsets (command codes).
	localparam logic [7:0] over_temp_warn_threshold_addr       = 8'h51;
	localparam logic [7:0] input_overvolt_warn_threshold_addr  = 8'h57;
	localparam logic [7:0] input_undervolt_warn_threshold_addr = 8'h58;
	localparam logic [7:0] summary_flags_low_addr              = 8'h78;
	localparam logic [7:0] summary_flags_full_addr             = 8'h79;
	localparam logic [7:0] output_voltage_flags_addr           = 8'h7a;
	localparam logic [7:0] input_side_flags_addr               = 8'h7c;
	localparam logic [7:0] clear_faults_cmd                    = 8'h03;
	// Threshold resets and special codes.
	localparam logic [15:0] over_temp_warn_reset        = 16'h07d0;
	localparam logic [15:0] input_overvolt_warn_reset   = 16'h0fff;
	localparam logic [15:0] input_undervolt_warn_reset  = 16'h0000;
	localparam logic [11:0] threshold_disable_high      = 12'hfff;
	localparam logic [11:0] threshold_disable_low       = 12'h000;
	// Summary byte bit positions.
	localparam int summary_off_bit      = 6;
	localparam int summary_in_uv_bit    = 3;
	localparam int summary_temp_bit     = 2;
	localparam int summary_comm_bit     = 1;
	localparam int summary_other_bit    = 0;
	// Summary word upper bit positions.
	localparam int summary_output_voltage_bit     = 15;
	localparam int summary_input_bit    = 13;
	localparam int summary_vendor_bit   = 12;
	localparam int summary_pgood_bit    = 11;
	// Output voltage and input status bit positions.
	localparam int output_voltage_uv_warn_bit     = 5;
	localparam int in_ov_fault_bit      = 7;
	localparam int in_ov_warn_bit       = 6;
	localparam int input_undervolt_warn_flag_bit       = 5;
	localparam int in_uv_fault_bit      = 4;
	localparam int in_oc_fault_bit      = 2;
	localparam int in_oc_warn_bit       = 1;
	localparam int in_op_warn_bit       = 0;
	// Temperature averaging: sixteen round-robin cycles of 1 ms each.
	localparam int temp_avg_samples     = 16;
	localparam int temp_avg_shift       = 4;
	localparam int clk_freq_hz          = 200_000_000;
	localparam int round_robin_us       = 1000;
	localparam int round_robin_cycles   = clk_freq_hz / 1_000_000 * round_robin_us;
endpackage

/* verilog/temp_averager.sv */
// Sixteen-sample running accumulator that yields one averaged temperature.
`timescale 1ns/1ps
`default_nettype none
module temp_averager (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Raw samples.
	input  wire logic [11:0] sample,
	input  wire logic        sample_valid,
	// Averaged result.
	output logic      [11:0] average,
	output logic             average_valid
);
	logic [15:0] sum_reg;
	logic [15:0] sum_next;
	logic [3:0]  count_reg;
	logic [3:0]  count_next;
	logic [11:0] avg_reg;
	logic [11:0] avg_next;
	logic        valid_reg;
	logic        valid_next;

	// The sum is exact for sixteen 12-bit samples; shifting keeps it cheap.
	always_comb begin
		sum_next   = sum_reg;
		count_next = count_reg;
		avg_next   = avg_reg;
		valid_next = 1'b0;
		if (sample_valid) begin
			if (count_reg == 4'(hotswap_flags_pkg::temp_avg_samples - 1)) begin
				avg_next = 12'((sum_reg + {4'h0, sample})
					>> hotswap_flags_pkg::temp_avg_shift);
				valid_next = 1'b1;
				sum_next   = 16'h0000;
				count_next = 4'h0;
			end else begin
				sum_next   = sum_reg + {4'h0, sample};
				count_next = count_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sum_reg   <= 16'h0000;
			count_reg <= 4'h0;
			avg_reg   <= 12'h000;
			valid_reg <= 1'b0;
		end else begin
			sum_reg   <= sum_next;
			count_reg <= count_next;
			avg_reg   <= avg_next;
			valid_reg <= valid_next;
		end
	end

	assign average       = avg_reg;
	assign average_valid = valid_reg;
endmodule // temp_averager
`default_nettype wire

/* tb/warn_flags_monitor.sv */
// Port checker for the warning thresholds, status flags and alert line.
`timescale 1ns/1ps
`default_nettype none
module warn_flags_monitor (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        sys_rst,
	// Register access.
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_write,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic        send_byte,
	input wire logic [7:0]  send_cmd,
	// Telemetry, switch state and alert.
	input wire logic [11:0] input_voltage,
	input wire logic        input_voltage_valid,
	input wire logic        switch_on,
	input wire logic        alert_oe_n
);
	logic [15:0] ov_lim_reg;
	logic [15:0] uv_lim_reg;
	logic        clr_cmd;
	assign clr_cmd = send_byte && send_cmd == 8'h03;
	// Mirror of the voltage thresholds, so alerts can be tied to samples.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ov_lim_reg <= 16'h0fff;
			uv_lim_reg <= 16'h0000;
		end else if (reg_write && reg_addr == 8'h57) begin
			ov_lim_reg <= reg_wdata;
		end else if (reg_write && reg_addr == 8'h58) begin
			uv_lim_reg <= reg_wdata;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_off_bit: assert property (
		reg_read && reg_addr == 8'h78 |=> reg_rdata[6] == !$past(switch_on))
		else $error("summary off bit does not follow the switch");
	a_byte_unsup: assert property (
		reg_read && reg_addr == 8'h78
		|=> reg_rdata[15:7] == 9'h000 && reg_rdata[5:4] == 2'b00)
		else $error("unsupported summary byte bit set");
	a_word_unsup: assert property (
		reg_read && reg_addr == 8'h79
		|=> !reg_rdata[14] && reg_rdata[10:8] == 3'b000
		&& reg_rdata[6] == !$past(switch_on))
		else $error("summary word fixed bits wrong");
	a_output_voltage_only: assert property (
		reg_read && reg_addr == 8'h7a |=> (reg_rdata & 16'hffdf) == 16'h0000)
		else $error("output voltage flags show a dead bit");
	a_input_unsup: assert property (
		reg_read && reg_addr == 8'h7c
		|=> reg_rdata[15:8] == 8'h00 && !reg_rdata[3])
		else $error("input flags show a dead bit");
	a_alert_sticky: assert property (
		!alert_oe_n && !clr_cmd |=> !alert_oe_n)
		else $error("alert released without a fault clear");
	a_ov_alert: assert property (
		input_voltage_valid && ov_lim_reg[11:0] != 12'hfff
		&& input_voltage > ov_lim_reg[11:0] |-> ##[1:2] !alert_oe_n)
		else $error("over-voltage sample did not raise alert");
	a_uv_alert: assert property (
		input_voltage_valid && uv_lim_reg[11:0] != 12'h000
		&& input_voltage < uv_lim_reg[11:0] |-> ##[1:2] !alert_oe_n)
		else $error("under-voltage sample did not raise alert");
	c_clear: cover property (clr_cmd ##1 alert_oe_n);
	c_alert: cover property ($fell(alert_oe_n));
	c_word_read: cover property (reg_read && reg_addr == 8'h79);
	c_lim_write: cover property (reg_write && reg_addr == 8'h58);
endmodule // warn_flags_monitor
`default_nettype wire

/* tb/host_bus_model.sv */
// Host model that issues register reads, writes and send-byte commands.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	// Clock.
	input  wire logic        clk,
	// Register access toward the block.
	output logic      [7:0]  reg_addr = 8'h00,
	output logic             reg_write = 1'b0,
	output logic      [15:0] reg_wdata = 16'h0000,
	output logic             reg_read = 1'b0,
	output logic             send_byte = 1'b0,
	output logic      [7:0]  send_cmd = 8'h00
);
	// Strobes last one cycle; idle lines show inverted values, so a design
	// that samples them outside a strobe sees the mistake.
	task automatic go(input int k, input logic [7:0] a,
		input logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		send_cmd = a;
		reg_write = (k == 1);
		reg_read = (k == 2);
		send_byte = (k == 3);
		@(negedge clk);
		reg_write = 1'b0;
		reg_read = 1'b0;
		send_byte = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
		send_cmd = ~a;
	endtask
endmodule // host_bus_model
`default_nettype wire

/* tb/hotswap_warn_limits_and_status_flags_tb_top.sv */
// Self-checking bench for the warning thresholds and status flags.
`timescale 1ns/1ps
`default_nettype none
module hotswap_warn_limits_and_status_flags_tb_top;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  reg_addr, send_cmd;
	logic        reg_write, reg_read, send_byte, alert_out, alert_oe_n;
	logic [15:0] reg_wdata, reg_rdata;
	logic [11:0] temp_sample = 12'h000;
	logic [11:0] input_voltage = 12'h000;
	logic        temp_sample_valid = 1'b0;
	logic        input_voltage_valid = 1'b0;
	logic        switch_on = 1'b0;
	logic        above_lockout = 1'b0;
	logic        rd_d = 1'b0;
	logic [9:0]  ev = 10'h000;
	logic [15:0] exp_q[$];
	int          error_cnt = 0;
	int          n_tests = 0;
	wire input_undervolt_fault_event = ev[0];
	wire input_overvolt_fault_event = ev[1];
	wire input_overcurrent_fault_event = ev[2];
	wire input_overcurrent_warn_event = ev[3];
	wire input_overpower_warn_event = ev[4];
	wire output_undervolt_warn_event = ev[5];
	wire over_temp_fault_event = ev[6];
	wire communication_fault_event = ev[7];
	wire vendor_specific_event = ev[8];
	wire power_good_negated_event = ev[9];
	// The alert line has a pull-up; the block only ever pulls it low.
	wire alert_line = alert_oe_n ? 1'b1 : alert_out;
	localparam logic [15:0] ev_word [10] = '{16'h2008, 16'h2001, 16'h2001,
		16'h2001, 16'h2001, 16'h8001, 16'h0004, 16'h0002, 16'h1001, 16'h0801};
	localparam logic [7:0] ev_addr [10] = '{8'h7c, 8'h7c, 8'h7c, 8'h7c,
		8'h7c, 8'h7a, 8'h78, 8'h78, 8'h78, 8'h78};
	localparam logic [15:0] ev_byte [10] = '{16'h0010, 16'h0080, 16'h0004,
		16'h0002, 16'h0001, 16'h0020, 16'h0004, 16'h0002, 16'h0001, 16'h0001};
	hotswap_warn_limits_and_status_flags dut (.*);
	host_bus_model host (.*);
	always #2.5 clk = ~clk;
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Read data stands from the taking edge on; it is checked at the next falling edge.
	always @(posedge clk) rd_d <= reg_read;
	always @(negedge clk) if (rd_d) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		host.go(2, a, 16'h0000);
	endtask
	task automatic alert(input logic e);
		chk("alert_line", {15'h0000, e}, {15'h0000, alert_line});
	endtask
	task automatic feed(input bit t, input logic [11:0] v, input int n);
		repeat (n) begin
			@(negedge clk);
			temp_sample = v;
			input_voltage = v;
			temp_sample_valid = t;
			input_voltage_valid = !t;
			@(negedge clk);
			temp_sample_valid = 1'b0;
			input_voltage_valid = 1'b0;
			temp_sample = ~v;
			input_voltage = ~v;
			repeat (3) @(negedge clk);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		$display("[ERR] run length expected end seen hang");
		results();
	end
	initial begin
		logic [15:0] d;
		logic [11:0] v;
		logic [7:0]  thr_addr;
		void'($urandom(32'h45bf6994));
		repeat (20) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		ev = 10'h000;
		rd(8'h51, 16'h07d0);
		rd(8'h57, 16'h0fff);
		rd(8'h58, 16'h0000);
		rd(8'h78, 16'h0049);
		rd(8'h79, 16'h3849);
		rd(8'h7c, 16'h0020);
		rd(8'h7a, 16'h0000);
		rd(8'h60, 16'h0000);
		$display("test reset values done");
		switch_on = 1'b1;
		above_lockout = 1'b1;
		repeat (6) @(negedge clk);
		rd(8'h7c, 16'h0000);
		rd(8'h79, 16'h1801);
		host.go(3, 8'h03, 16'h0000);
		above_lockout = 1'b0;
		rd(8'h79, 16'h0000);
		alert(1'b1);
		$display("test lockout exit done");
		for (int i = 0; i < 3; i++) begin
			d = 16'($urandom);
			thr_addr = (i == 0) ? 8'h51 : 8'h56 + 8'(i);
			host.go(1, thr_addr, d);
			rd(thr_addr, d);
		end
		host.go(1, 8'h78, 16'hffff);
		rd(8'h78, 16'h0000);
		$display("test threshold words done");
		v = 12'h100 + 12'($urandom_range(0, 12'hd00));
		host.go(1, 8'h58, 16'h0000);
		host.go(1, 8'h57, {4'h0, v});
		feed(1'b0, v, 1);
		rd(8'h7c, 16'h0000);
		feed(1'b0, v + 12'h001, 1);
		rd(8'h7c, 16'h0040);
		rd(8'h79, 16'h2001);
		alert(1'b0);
		feed(1'b0, v - 12'h001, 1);
		rd(8'h7c, 16'h0040);
		host.go(3, 8'h03, 16'h0000);
		rd(8'h7c, 16'h0000);
		host.go(1, 8'h57, 16'h0fff);
		host.go(1, 8'h58, {4'h0, v});
		feed(1'b0, v, 1);
		rd(8'h7c, 16'h0000);
		feed(1'b0, v - 12'h001, 1);
		rd(8'h7c, 16'h0020);
		alert(1'b0);
		host.go(3, 8'h03, 16'h0000);
		feed(1'b0, v - 12'h002, 1);
		rd(8'h7c, 16'h0020);
		host.go(3, 8'h03, 16'h0000);
		feed(1'b0, v + 12'h001, 1);
		rd(8'h7c, 16'h0000);
		alert(1'b1);
		$display("test input voltage warnings done");
		host.go(1, 8'h51, {4'h0, v});
		feed(1'b1, v, 16);
		rd(8'h78, 16'h0000);
		feed(1'b1, v + 12'h001, 15);
		rd(8'h78, 16'h0000);
		feed(1'b1, v + 12'h001, 1);
		rd(8'h78, 16'h0004);
		rd(8'h79, 16'h0004);
		alert(1'b0);
		host.go(3, 8'h03, 16'h0000);
		rd(8'h78, 16'h0000);
		$display("test temperature warning done");
		for (int i = 0; i < 10; i++) begin
			@(negedge clk);
			ev[i] = 1'b1;
			@(negedge clk);
			ev[i] = 1'b0;
			rd(8'h79, ev_word[i]);
			rd(ev_addr[i], ev_byte[i]);
			host.go(3, 8'h03, 16'h0000);
		end
		$display("test event flags done");
		switch_on = 1'b0;
		rd(8'h78, 16'h0040);
		rd(8'h79, 16'h0040);
		switch_on = 1'b1;
		$display("test switch off done");
		repeat (3) @(negedge clk);
		chk("pending reads", 16'h0000, 16'(exp_q.size()));
		results();
	end
endmodule // hotswap_warn_limits_and_status_flags_tb_top
bind hotswap_warn_limits_and_status_flags warn_flags_monitor mon (.*);
`default_nettype wire
